//--- hdl/csbi_bus_if.sv
/*
  Processor side of the system bus: machine-cycle sequencer, multiplexed
  address, strobes, timing pulses, state code, I/O selects, flags,
  interrupt entry and cycle-stealing DMA. The instruction stream is
  supplied by a core through opcode_in; this block only runs the bus.
  Assumes synchronous inputs and a single 100 MHz clock.
*/
`timescale 1ns/100ps
module csbi_bus_if
  import csbi_pkg::*;
(
  input  wire logic        sys_clk_in,          // 100 MHz clock
  input  wire logic        rst_n_in,            // Async active-low reset
  input  wire logic        clk_en_in,           // Freeze when low
  input  wire logic        clear_level_n_in,    // Mode input, clear
  input  wire logic        wait_level_n_in,     // Mode input, wait
  input  wire logic [7:0]  opcode_in,           // Next instruction code
  input  wire logic        irq_n_in,            // Interrupt line
  input  wire logic        dma_in_request_n_in, // DMA into memory
  input  wire logic        dma_out_request_n_in,// DMA out of memory
  input  wire logic        flag_input_one_in,   // Port A ready
  input  wire logic        flag_input_two_in,   // Port B ready
  input  wire logic        flag_input_three_in, // Flag three
  input  wire logic        flag_input_four_in,  // Flag four
  input  wire logic        serial_data_in,      // Serial receive data
  input  wire logic        serial_input_jumper_in, // 1: flag four
  input  wire logic [7:0]  data_in,             // Data bus in
  output logic [7:0]       data_out,            // Data bus out
  output logic             data_oe_out,         // Drive data bus
  output logic [7:0]       addr_out,            // Multiplexed address
  output logic             memory_read_strobe_out,
  output logic             memory_write_strobe_out,
  output logic             first_timing_pulse_out,
  output logic             second_timing_pulse_out,
  output logic             state_code_high_out,
  output logic             state_code_low_out,
  output logic [2:0]       io_select_lines_out,
  output logic [3:0]       flags_out,           // Flags seen by branches
  output logic             flag_output_bit_out, // Serial output bit
  output logic             irq_allow_out,       // Interrupt enable
  output logic [7:0]       backup_field_out,    // Saved selectors
  output logic [15:0]      dma_pointer_reg_out, // DMA address register
  output logic             bus_clk_out          // 2 MHz bus clock
);
  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  logic rst_meta, rst_sync;               // Two-stage release
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // Mode and timing
  // ------------------------------------------------------------
  wire [1:0] mode      = {clear_level_n_in, wait_level_n_in};
  wire       mode_rst  = (mode == MODE_RESET);
  wire       mode_load = (mode == MODE_LOAD);
  wire       run_ok    = (mode != MODE_PAUSE);                  // Pause stops phases
  logic        tick;                      // Bus clock falling edge
  logic [3:0]  phase;                     // Phase within machine cycle
  logic        in_init;                   // Initialisation cycle
  csbi_state_t state;                     // Current machine state
  wire  [3:0]  last_phase = in_init ? 4'(INIT_PHASES - 1) : 4'(PHASES_PER_CYCLE - 1);
  wire         cyc_end    = tick && run_ok && !mode_rst && (phase == last_phase);

  csbi_timing u_timing (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_sync),
    .clk_en_in   (clk_en_in),
    .run_in      (run_ok && !mode_rst),
    .clear_in    (mode_rst),
    .last_in     (last_phase),
    .bus_clk_out (bus_clk_out),
    .tick_out    (tick),
    .phase_out   (phase)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic [7:0]  opcode;                    // Latched instruction
  logic [3:0]  data_sel, cnt_sel;         // Pointer selectors
  logic [15:0] pc;                        // Active program counter
  wire is_io  = (opcode[7:4] == OP_IO_BASE[7:4]) && (opcode[3:0] != 4'h0) && (opcode[2:0] != 3'h0);
  wire io_cyc = (state == CSBI_EXECUTE) && is_io && !in_init;
  wire dma_req  = !dma_in_request_n_in || !dma_out_request_n_in;
  wire irq_take = !irq_n_in && irq_allow_out;
  logic        dma_to_mem;                // Direction latched at DMA entry
  // Request may drop at the first pulse, so direction must not follow it
  wire dma_in   = dma_to_mem;

  // Next machine state; init blocks DMA and interrupt
  csbi_state_t next_state;
  always_comb begin
    case (state)
      CSBI_FETCH:   next_state = CSBI_EXECUTE;
      CSBI_EXECUTE,
      CSBI_DMA,
      CSBI_IRQ: begin
        if (dma_req && !in_init) begin
          next_state = CSBI_DMA;                  // Stolen cycle
        end else if (irq_take && !in_init && state != CSBI_IRQ) begin
          next_state = CSBI_IRQ;                  // After instruction
        end else if (mode_load) begin
          next_state = state == CSBI_IRQ ? CSBI_FETCH : CSBI_EXECUTE; // Idle while loading
        end else begin
          next_state = CSBI_FETCH;
        end
      end
      default:      next_state = CSBI_FETCH;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer and architectural bits
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      state               <= CSBI_EXECUTE;
      in_init             <= 1'b1;
      opcode              <= 8'h00;
      data_sel            <= 4'h0;
      cnt_sel             <= 4'h0;
      pc                  <= 16'h0000;
      irq_allow_out       <= 1'b1;
      flag_output_bit_out <= 1'b0;
      backup_field_out    <= 8'h00;
      dma_pointer_reg_out <= 16'h0000;
      dma_to_mem          <= 1'b0;
    end else if (clk_en_in) begin
      if (mode_rst) begin
        // Held in execute; init cycle follows release
        state               <= CSBI_EXECUTE;
        in_init             <= 1'b1;
        irq_allow_out       <= 1'b1;
        flag_output_bit_out <= 1'b0;
        opcode              <= 8'h00;
      end else if (cyc_end) begin
        state <= next_state;
        if (next_state == CSBI_DMA) begin
          dma_to_mem <= !dma_in_request_n_in;
        end
        if (in_init) begin
          // Clear selectors and DMA pointer
          in_init             <= 1'b0;
          data_sel            <= 4'h0;
          cnt_sel             <= 4'h0;
          dma_pointer_reg_out <= 16'h0000;
        end
        if (state == CSBI_FETCH) begin
          opcode <= opcode_in;
          pc     <= pc + 16'h0001;
        end
        if (state == CSBI_EXECUTE && !in_init) begin
          if (opcode == OP_SET_FLAG) flag_output_bit_out <= 1'b1;
          if (opcode == OP_CLR_FLAG) flag_output_bit_out <= 1'b0;
        end
        if (state == CSBI_DMA) begin
          dma_pointer_reg_out <= dma_pointer_reg_out + 16'h0001;
        end
        if (state == CSBI_IRQ) begin
          backup_field_out <= {data_sel, cnt_sel};
          data_sel         <= IRQ_DATA_SEL;
          cnt_sel          <= IRQ_CNT_SEL;
          irq_allow_out    <= 1'b0;
          pc               <= 16'h0000;   // Counter register restarts
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Bus outputs
  // ------------------------------------------------------------
  wire [15:0] cur_addr  = (state == CSBI_DMA) ? dma_pointer_reg_out : pc;
  wire        active    = !mode_rst;           // Pulses suppressed in reset
  wire        wr_window = (phase >= 4'(PHASE_WR_FIRST)) && (phase <= 4'(PHASE_WR_LAST));
  wire        mem_wr    = (state == CSBI_DMA && dma_in) || (io_cyc && opcode[3]);
  wire        mem_rd    = (state == CSBI_FETCH) || (state == CSBI_DMA && !dma_in);

  always_ff @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      addr_out                <= 8'h00;
      memory_read_strobe_out  <= 1'b0;
      memory_write_strobe_out <= 1'b0;
      first_timing_pulse_out  <= 1'b0;
      second_timing_pulse_out <= 1'b0;
      state_code_high_out     <= 1'b0;
      state_code_low_out      <= 1'b1;      // Reset holds the execute code
      io_select_lines_out     <= 3'h0;
      flags_out               <= 4'h0;
      data_out                <= 8'h00;
      data_oe_out             <= 1'b0;
    end else if (clk_en_in) begin
      // High byte first, low byte later in the cycle
      addr_out <= (phase < 4'(PHASE_ADDR_LOW)) ? cur_addr[15:8] : cur_addr[7:0];
      // One pulse each per cycle
      first_timing_pulse_out  <= active && (phase == 4'(PHASE_TPA));
      second_timing_pulse_out <= active && (phase == 4'(PHASE_TPB));
      // Write only mid-cycle, address stable
      memory_write_strobe_out <= active && mem_wr && wr_window && !in_init;
      // Direction bit during I/O, else read cycles
      memory_read_strobe_out  <= io_cyc ? opcode[3] : (active && mem_rd);
      // State code
      state_code_high_out     <= state[1];
      state_code_low_out      <= state[0];
      // Selects only during I/O
      io_select_lines_out     <= io_cyc ? opcode[2:0] : 3'h0;
      // Serial data steered by jumper
      flags_out <= {serial_input_jumper_in ? serial_data_in : flag_input_four_in,
                    serial_input_jumper_in ? flag_input_three_in : serial_data_in,
                    flag_input_two_in, flag_input_one_in};
      data_out    <= mode_rst ? 8'h00 : data_in;
      data_oe_out <= mode_rst || (mem_wr && !in_init && phase >= 4'(PHASE_ADDR_LOW));
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  irq_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (state == CSBI_IRQ && cyc_end) |-> phase == 4'(PHASES_PER_CYCLE - 1) ##1 state != CSBI_IRQ)
    else $error("interrupt state length wrong");
  dma_rd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (state == CSBI_DMA && !dma_to_mem && clk_en_in && !mode_rst)
    |=> memory_read_strobe_out && !memory_write_strobe_out)
    else $error("DMA-out cycle not a memory read");
  irq_clr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (state == CSBI_IRQ && cyc_end) |=> !irq_allow_out && data_sel == IRQ_DATA_SEL)
    else $error("interrupt entry values wrong");
  dma_inc_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (state == CSBI_DMA && cyc_end) |=> dma_pointer_reg_out == $past(dma_pointer_reg_out) + 16'h0001)
    else $error("DMA pointer not incremented");
  io_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    !io_cyc |=> io_select_lines_out == 3'h0)
    else $error("I/O select active outside I/O");
  code_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    ##1 {state_code_high_out, state_code_low_out} == $past(state))
    else $error("state code mismatch");
  wr_win_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    memory_write_strobe_out |-> addr_out == $past(cur_addr[7:0]))
    else $error("write strobe without stable low address");
  flag_set_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (state == CSBI_EXECUTE && !in_init && opcode == OP_SET_FLAG && cyc_end && !mode_rst) |=> flag_output_bit_out)
    else $error("flag output not set");
  init_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    (in_init && cyc_end) |=> state != CSBI_IRQ && dma_pointer_reg_out == 16'h0000)
    else $error("init cycle misbehaved");
  dir_a: assert property (@(posedge sys_clk_in) disable iff (!rst_sync)
    io_cyc |=> memory_read_strobe_out == $past(opcode[3]))
    else $error("I/O direction wrong");
endmodule

//--- hdl/csbi_pkg.sv
/*
  Package for the processor system bus interface: machine-state codes,
  timing constants, opcodes and the register indices the sequencer uses.
  Assumes a single 100 MHz system clock and no register bus.
*/
// Operation
// - I/O select lines carry low code bits
// - Read strobe shows I/O direction bit
// - Four flag inputs, first two ports ready
// - Serial input jumpered onto flag four/three
// - Interrupt ends instruction, saves selectors
// - Interrupt sets selectors, clears irq_allow
// - Interrupt state lasts one machine cycle
// - DMA uses pointer register, auto increments
// - DMA state eight clocks, interleaved
// - Two-bit machine state code output
// - Two timing pulses once per cycle
// - Address multiplexed high then low byte
// - Write strobe only with stable address
// - Opcodes set/clear flag output bit
// - Free-running bus clock from oscillator
// - Mode inputs select load/reset/pause/run
// - Nine-clock init cycle after reset
package csbi_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int SYS_CLK_MHZ      = 100;        // System clock rate
  localparam int BUS_CLK_MHZ      = 2;          // Bus clock rate
  localparam int BUS_HALF_CYCLES  = SYS_CLK_MHZ / (2 * BUS_CLK_MHZ);
  localparam int PHASES_PER_CYCLE = 8;          // Bus clocks per machine cycle
  localparam int INIT_PHASES      = 9;          // Init cycle length
  localparam int PHASE_TPA        = 1;          // First pulse phase
  localparam int PHASE_ADDR_LOW   = 2;          // Low byte from here on
  localparam int PHASE_WR_FIRST   = 5;          // Write strobe window
  localparam int PHASE_WR_LAST    = 6;
  localparam int PHASE_TPB        = 7;          // Second pulse phase

  // ------------------------------------------------------------
  // Machine-state codes
  // ------------------------------------------------------------
  // Declaration order yields the two-bit bus state code
  typedef enum logic [1:0] {
    CSBI_FETCH,
    CSBI_EXECUTE,
    CSBI_DMA,
    CSBI_IRQ
  } csbi_state_t;

  // ------------------------------------------------------------
  // Opcodes and register indices
  // ------------------------------------------------------------
  localparam logic [7:0] OP_SET_FLAG   = 8'h7b;
  localparam logic [7:0] OP_CLR_FLAG   = 8'h7a;
  localparam logic [7:0] OP_IO_BASE    = 8'h60;   // I/O group 6x
  localparam logic [3:0] IRQ_DATA_SEL  = 4'h2;
  localparam logic [3:0] IRQ_CNT_SEL   = 4'h1;
  localparam logic [3:0] DMA_PTR_IDX   = 4'h0;

  // ------------------------------------------------------------
  // Mode encodings (clear-level, wait-level)
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_LOAD  = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam logic [1:0] MODE_PAUSE = 2'h2;
  localparam logic [1:0] MODE_RUN   = 2'h3;

endpackage

//--- hdl/csbi_timing.sv
/*
  Bus clock divider and machine-cycle phase counter.
  Assumes a clock enable freezing all state and a synchronous reset copy.
*/
`timescale 1ns/100ps
module csbi_timing
  import csbi_pkg::*;
(
  input  wire logic       sys_clk_in,    // System clock
  input  wire logic       rst_n_in,      // Synchronised reset
  input  wire logic       clk_en_in,     // Global freeze
  input  wire logic       run_in,        // Phase counter runs
  input  wire logic       clear_in,      // Restart phase count
  input  wire logic [3:0] last_in,       // Last phase of this cycle
  output logic            bus_clk_out,   // Free running bus clock
  output logic            tick_out,      // Bus clock falling edge pulse
  output logic [3:0]      phase_out      // Current phase
);
  // ------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------
  logic [7:0] div_cnt;                   // Half period counter
  wire        half_done = (div_cnt == 8'(BUS_HALF_CYCLES - 1));
  assign tick_out = half_done && bus_clk_out && clk_en_in;

  // Bus clock keeps running in every mode
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt     <= 8'h00;
      bus_clk_out <= 1'b0;
    end else if (clk_en_in) begin
      div_cnt     <= half_done ? 8'h00 : div_cnt + 8'h01;
      if (half_done) begin
        bus_clk_out <= ~bus_clk_out;
      end
    end
  end

  // Phase advances per bus clock, wraps at end of machine cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_out <= 4'h0;
    end else if (clk_en_in && clear_in) begin
      // Reset mode restarts the cycle so init gets all its phases
      phase_out <= 4'h0;
    end else if (tick_out && run_in) begin
      phase_out <= (phase_out == last_in) ? 4'h0 : phase_out + 4'h1;
    end
  end
endmodule

//--- tb/csbi_bus_partner.sv
/*
  Far-side model: one expansion memory board plus a DMA controller.
  Assumes the device's strobes and pulses are active high and registered.
*/
`timescale 1ns/100ps
module csbi_bus_partner (
  input  wire logic        sys_clk_in,        // System clock
  input  wire logic        rst_n_in,          // Active-low reset
  input  wire logic [7:0]  addr_in,           // Multiplexed address
  input  wire logic        rd_in,             // Read strobe
  input  wire logic        wr_in,             // Write strobe
  input  wire logic        pulse1_in,         // First timing pulse
  input  wire logic        pulse2_in,         // Second timing pulse
  input  wire logic [1:0]  state_in,          // Machine-state code
  input  wire logic [7:0]  cpu_data_in,       // Data driven by the device
  input  wire logic        dma_go_in,         // Start one DMA byte
  input  wire logic        dma_dir_in,        // 1: into memory
  input  wire logic [7:0]  dma_byte_in,       // Byte the controller supplies
  output logic [7:0]       bus_data_out,      // Data seen by the device
  output logic             dma_in_req_n_out,  // DMA-in request
  output logic             dma_out_req_n_out, // DMA-out request
  output logic [15:0]      wr_addr_out,       // Last write address
  output logic [7:0]       wr_data_out,       // Last write data
  output logic [7:0]       port_out           // Output port latch
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] mem [256];                      // Low-byte indexed store
  logic [7:0] hi_addr, addr_d, last_bus;      // Own high-byte latch
  logic       p1_d, p2_d, wr_d, req, dir;     // Edge finders, request
  wire        dma_cyc = (state_in == 2'h2);   // Device in DMA state

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h3c;
  end

  // Drive under read or in a DMA-in cycle; a released bus shows a changing filler
  always_comb begin
    if (rd_in) begin
      bus_data_out = mem[addr_in];
    end else if (dma_cyc && dir) begin
      bus_data_out = dma_byte_in;
    end else begin
      bus_data_out = ~last_bus;
    end
  end

  assign dma_in_req_n_out  = !(req && dir);
  assign dma_out_req_n_out = !(req && !dir);

  // Trailing-edge latches; addr_d holds the value before the edge
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {p1_d, p2_d, wr_d, req, dir} <= 5'h00;
      {hi_addr, addr_d, last_bus, port_out, wr_data_out} <= 40'h0;
      wr_addr_out <= 16'h0;
    end else begin
      {p1_d, p2_d, wr_d} <= {pulse1_in, pulse2_in, wr_in};
      addr_d   <= addr_in;
      last_bus <= bus_data_out;
      if (dma_go_in) begin
        req <= 1'b1;
        dir <= dma_dir_in;
      end
      if (p1_d && !pulse1_in) begin
        hi_addr <= addr_d;
        if (dma_cyc) req <= 1'b0;
      end
      if (wr_d && !wr_in) begin
        mem[addr_d] <= (dma_cyc && dir) ? dma_byte_in : cpu_data_in;
        wr_addr_out <= {hi_addr, addr_d};
        wr_data_out <= (dma_cyc && dir) ? dma_byte_in : cpu_data_in;
      end
      if (p2_d && !pulse2_in) port_out <= cpu_data_in;
    end
  end
endmodule

//--- tb/csbi_bus_if_test.sv
/*
  Self-checking bench for the system bus interface.
  Assumes the partner model on the far side and inputs driven at falling edges.
*/
`timescale 1ns/100ps
module csbi_bus_if_test;
  import csbi_pkg::*;
  // ------------------------------------------------------------
  // Signals, named as the design's ports
  // ------------------------------------------------------------
  logic        sys_clk_in, rst_n_in, clk_en_in, clear_level_n_in, wait_level_n_in, irq_n_in;
  logic        flag_input_one_in, flag_input_two_in, flag_input_three_in, flag_input_four_in;
  logic        serial_data_in, serial_input_jumper_in, dma_go, dma_dir;
  logic        dma_in_request_n_in, dma_out_request_n_in, data_oe_out, bus_clk_out;
  logic        memory_read_strobe_out, memory_write_strobe_out, first_timing_pulse_out;
  logic        second_timing_pulse_out, state_code_high_out, state_code_low_out;
  logic        flag_output_bit_out, irq_allow_out;
  logic [7:0]  opcode_in, data_in, data_out, addr_out, backup_field_out, wr_data, port_data;
  logic [2:0]  io_select_lines_out, cur, prev;
  logic [3:0]  flags_out;
  logic [15:0] dma_pointer_reg_out, wr_addr;
  int          failures, check_count, cycles, n, rises [3];
  wire  [1:0]  state = {state_code_high_out, state_code_low_out};

  csbi_bus_if dut_u (.sys_clk_in, .rst_n_in, .clk_en_in, .clear_level_n_in, .wait_level_n_in,
    .opcode_in, .irq_n_in, .dma_in_request_n_in, .dma_out_request_n_in, .flag_input_one_in,
    .flag_input_two_in, .flag_input_three_in, .flag_input_four_in, .serial_data_in,
    .serial_input_jumper_in, .data_in, .data_out, .data_oe_out, .addr_out, .memory_read_strobe_out,
    .memory_write_strobe_out, .first_timing_pulse_out, .second_timing_pulse_out, .state_code_high_out,
    .state_code_low_out, .io_select_lines_out, .flags_out, .flag_output_bit_out, .irq_allow_out,
    .backup_field_out, .dma_pointer_reg_out, .bus_clk_out);

  csbi_bus_partner partner_u (.sys_clk_in, .rst_n_in, .addr_in(addr_out), .rd_in(memory_read_strobe_out),
    .wr_in(memory_write_strobe_out), .pulse1_in(first_timing_pulse_out),
    .pulse2_in(second_timing_pulse_out), .state_in(state), .cpu_data_in(data_out), .dma_go_in(dma_go),
    .dma_dir_in(dma_dir), .dma_byte_in(8'ha5), .bus_data_out(data_in), .dma_in_req_n_out(dma_in_request_n_in),
    .dma_out_req_n_out(dma_out_request_n_in), .wr_addr_out(wr_addr), .wr_data_out(wr_data), .port_out(port_data));

  // ------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // Whole run is about 9k cycles; the ceiling leaves ample margin
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      end_sim();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask

  // Bounded wait for a machine state, then its length in clocks
  task automatic state_len(input logic [1:0] c, output int len);
    for (int i = 0; i < 2000 && state !== c; i++) @(negedge sys_clk_in);
    len = 0;
    while (state === c && len < 5000) begin
      @(negedge sys_clk_in);
      len++;
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n_in, clk_en_in, clear_level_n_in, wait_level_n_in, irq_n_in} = 5'b01110;
    {flag_input_one_in, flag_input_two_in, flag_input_three_in, flag_input_four_in} = 4'h0;
    {serial_data_in, serial_input_jumper_in, dma_go, dma_dir} = 4'h0;
    opcode_in = 8'hc4;                        // Plain non-I/O opcode
    failures = 0;
    check_count = 0;
    cycles = 0;
    @(negedge sys_clk_in);
    check(state, 2'h1);
    check(irq_allow_out, 1'b1);
    @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    // Interrupt held from the start must wait out the init cycle
    for (int i = 0; i < 1000 && state === 2'h1; i++) @(negedge sys_clk_in);
    check(state, 2'h0);
    check(dma_pointer_reg_out, 16'h0);
    state_len(2'h3, n);
    check(n, 400);
    check(irq_allow_out, 1'b0);
    check(backup_field_out, 8'h00);
    irq_n_in = 1'b1;
    // Flag output bit set, then cleared
    opcode_in = OP_SET_FLAG;
    repeat (900) @(negedge sys_clk_in);
    check(flag_output_bit_out, 1'b1);
    opcode_in = OP_CLR_FLAG;
    repeat (900) @(negedge sys_clk_in);
    check(flag_output_bit_out, 1'b0);
    // I/O selects and direction for both directions
    for (int k = 0; k < 2; k++) begin
      opcode_in = (k == 0) ? 8'h6d : 8'h62;
      for (int i = 0; i < 1200 && io_select_lines_out !== opcode_in[2:0]; i++) @(negedge sys_clk_in);
      @(negedge sys_clk_in);
      check(io_select_lines_out, opcode_in[2:0]);
      check(memory_read_strobe_out, opcode_in[3]);
    end
    opcode_in = 8'hc4;
    repeat (900) @(negedge sys_clk_in);
    check(io_select_lines_out, 3'h0);
    // Flags with the serial input on either jumper position
    {flag_input_one_in, flag_input_three_in, serial_data_in, serial_input_jumper_in} = 4'hf;
    repeat (4) @(negedge sys_clk_in);
    check(flags_out, 4'hd);
    {flag_input_two_in, serial_input_jumper_in} = 2'b10;
    repeat (4) @(negedge sys_clk_in);
    check(flags_out, 4'h7);
    // Bus clock and pulses over one machine cycle
    rises = '{0, 0, 0};
    prev = {bus_clk_out, first_timing_pulse_out, second_timing_pulse_out};
    repeat (400) begin
      @(negedge sys_clk_in);
      cur = {bus_clk_out, first_timing_pulse_out, second_timing_pulse_out};
      for (int k = 0; k < 3; k++) if (cur[k] && !prev[k]) rises[k]++;
      prev = cur;
    end
    check(rises[2], 8);
    check(rises[1], 1);
    check(rises[0], 1);
    // Single-byte DMA into memory, then out of memory
    {dma_go, dma_dir} = 2'b11;
    @(negedge sys_clk_in);
    dma_go = 1'b0;
    state_len(2'h2, n);
    check(n, 400);
    check(dma_pointer_reg_out, 16'h1);
    check(wr_addr, 16'h0);
    check(wr_data, 8'ha5);
    {dma_go, dma_dir} = 2'b10;
    @(negedge sys_clk_in);
    dma_go = 1'b0;
    state_len(2'h2, n);
    check(n, 400);
    check(dma_pointer_reg_out, 16'h2);
    check(wr_addr, 16'h0);
    // Reset mode mid-run: execute held, pulses off, then a full init cycle
    {clear_level_n_in, wait_level_n_in} = 2'b01;
    n = 0;
    repeat (400) begin
      @(negedge sys_clk_in);
      if (first_timing_pulse_out !== 1'b0 || second_timing_pulse_out !== 1'b0) n++;
    end
    check(n, 0);
    check(state, 2'h1);
    check(irq_allow_out, 1'b1);
    check(data_out, 8'h00);
    check(data_oe_out, 1'b1);
    {clear_level_n_in, wait_level_n_in} = 2'b11;
    state_len(2'h1, n);
    check(n > 401 && n < 452, 1'b1);
    check(state, 2'h0);
    check(dma_pointer_reg_out, 16'h0);
    end_sim();
  end
endmodule
